// [ssr_receiver.sv]
// Purpose: Synchronous slave receive path of a serial port, with register port
// Assumes: External master drives clock and data; pins sampled by the 20 MHz clock
// Notes:   Data is taken on the rising edge of the sampled clock pin
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module ssr_receiver
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // Register port
  input  wire ssr_pkg::ssr_req_t req,
  output logic [7:0]          rdata,
  // Serial pins, never driven by this end
  input  wire logic           data_in,
  output logic                data_out,
  output logic                data_oe,
  input  wire logic           clk_in,
  output logic                clk_out,
  output logic                clk_oe,
  // Core signals
  output ssr_pkg::ssr_core_t  core,
  output logic                irq
);
  import ssr_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] baud_ctrl_q, core_irq_q, periph_prio_q, periph_en_q;
  logic [7:0] baud_lo_q, baud_hi_q, tx_status_q, pin_dir_q, evt_mask_q;
  logic [7:0] rx_ctrl_q;
  logic [7:0] hold_q;
  logic       hold_ninth_q;
  logic       recv_flag_q;
  logic       overrun_q;
  logic [1:0] evt_q;
  logic       sleep_q;
  logic [7:0] rdata_q;
  logic       irq_q;
  ssr_core_t  core_q;

  // Byte-wide write decode, used per register
  function automatic logic hit(input ssr_req_t r, input logic [3:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] dsync_q, csync_q;
  logic       clk_prev_q;
  wire        dat_s     = dsync_q[1];
  wire        clk_s     = csync_q[1];
  wire        clk_rise  = clk_s && !clk_prev_q;

  // Two stages before any logic reads the pins
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      dsync_q    <= 2'b00;
      csync_q    <= 2'b00;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      dsync_q    <= {dsync_q[0], data_in};
      csync_q    <= {csync_q[0], clk_in};
      clk_prev_q <= clk_s;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire port_en  = rx_ctrl_q[SSR_RS_PORT_EN];
  wire cont_en  = rx_ctrl_q[SSR_RS_CONT];
  wire ninth_en = rx_ctrl_q[SSR_RS_NINTH_EN];
  // Single-receive bit deliberately left out of the decode
  wire slave    = port_en && tx_status_q[SSR_TS_SYNC]
                  && !tx_status_q[SSR_TS_MASTER];
  // Once started the receiver runs on, sleep or not
  wire rx_run   = slave && cont_en;
  wire [3:0] word_bits = ninth_en ? SSR_BITS_9 : SSR_BITS_8;

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  ssr_state_t state_q, state_d;
  logic [8:0] shift_q;
  logic [3:0] cnt_q;
  wire        last_bit = clk_rise && (cnt_q == word_bits - SSR_CNT_ONE);
  wire        done     = (state_q == SSR_MOVE);

  // State sequencing; no idle return while running
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SSR_IDLE:  state_d = rx_run ? SSR_SHIFT : SSR_IDLE;
      SSR_SHIFT: state_d = !rx_run ? SSR_IDLE :
                           (last_bit ? SSR_MOVE : SSR_SHIFT);
      SSR_MOVE:  state_d = rx_run ? SSR_SHIFT : SSR_IDLE;
      default:   state_d = SSR_IDLE;
    endcase
  end

  // Bits arrive LSB first; word is right-aligned at completion
  always_ff @(posedge clk)
  begin
    if (!nrst || !rx_run)
    begin
      state_q <= SSR_IDLE;
      shift_q <= 9'h000;
      cnt_q   <= SSR_CNT_ZERO;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == SSR_SHIFT && clk_rise)
      begin
        shift_q <= ninth_en ? {dat_s, shift_q[8:1]} : {1'b0, dat_s, shift_q[7:1]};
        cnt_q   <= last_bit ? SSR_CNT_ZERO : cnt_q + SSR_CNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Holding register, flag and overrun
  // ----------------------------------------------------------------
  wire rd_hold   = req.rd && (req.addr == SSR_ADDR_RX_HOLD);
  wire rd_evt    = req.rd && (req.addr == SSR_ADDR_EVT_STATUS);
  wire overrun_e = done && recv_flag_q && !rd_hold;
  // Word move only while holding is free; overrun keeps old data
  wire load      = done && (!recv_flag_q || rd_hold);

  always_ff @(posedge clk)
  begin
    if (!nrst || !port_en)
    begin
      hold_q       <= SSR_RST_BYTE;
      hold_ninth_q <= 1'b0;
      recv_flag_q  <= 1'b0;
      overrun_q    <= 1'b0;
    end
    else
    begin
      if (load)
      begin
        hold_q       <= shift_q[7:0];
        hold_ninth_q <= ninth_en & shift_q[8];
      end
      // Set wins over the read that clears
      recv_flag_q <= load || (recv_flag_q && !rd_hold);
      overrun_q   <= cont_en && (overrun_q || overrun_e);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt, wake and event status
  // ----------------------------------------------------------------
  wire rc_en  = periph_en_q[SSR_PI_RECV];
  wire gl_en  = core_irq_q[SSR_CI_GLOBAL];
  wire pe_en  = core_irq_q[SSR_CI_PERIPH];
  wire irq_d  = recv_flag_q && rc_en && gl_en && pe_en;
  wire [1:0] evt_set = {overrun_e, load};
  wire [1:0] evt_pend = evt_q & evt_mask_q[1:0];
  // Wake only needs the receive enable; vector needs all three enables,
  // so a wake with the peripheral gate shut always resumes in line
  wire wake_d = sleep_q && recv_flag_q && rc_en;
  wire vec_d  = wake_d && gl_en && pe_en;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      evt_q  <= 2'b00;
      irq_q  <= 1'b0;
      core_q <= '0;
    end
    else
    begin
      // Read clears, new events survive the clearing read
      evt_q  <= evt_set | (rd_evt ? 2'b00 : evt_q);
      irq_q  <= irq_d || (|evt_pend);
      core_q <= '{wake: wake_d, vector: vec_d};
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      baud_ctrl_q   <= SSR_RST_BYTE;
      core_irq_q    <= SSR_RST_BYTE;
      periph_prio_q <= SSR_RST_BYTE;
      periph_en_q   <= SSR_RST_BYTE;
      baud_lo_q     <= SSR_RST_BYTE;
      baud_hi_q     <= SSR_RST_BYTE;
      tx_status_q   <= SSR_RST_BYTE;
      rx_ctrl_q     <= SSR_RST_BYTE;
      pin_dir_q     <= SSR_RST_PIN_DIR;
      evt_mask_q    <= SSR_RST_BYTE;
      sleep_q       <= 1'b0;
    end
    else
    begin
      if (hit(req, SSR_ADDR_BAUD_CTRL))   baud_ctrl_q   <= req.wdata;
      if (hit(req, SSR_ADDR_CORE_IRQ))    core_irq_q    <= req.wdata;
      if (hit(req, SSR_ADDR_PERIPH_PRIO)) periph_prio_q <= req.wdata;
      if (hit(req, SSR_ADDR_PERIPH_EN))   periph_en_q   <= req.wdata;
      if (hit(req, SSR_ADDR_BAUD_LO))     baud_lo_q     <= req.wdata;
      if (hit(req, SSR_ADDR_BAUD_HI))     baud_hi_q     <= req.wdata;
      if (hit(req, SSR_ADDR_TX_STATUS))   tx_status_q   <= req.wdata;
      if (hit(req, SSR_ADDR_RX_STATUS))   rx_ctrl_q     <= req.wdata;
      if (hit(req, SSR_ADDR_PIN_DIR))     pin_dir_q     <= req.wdata;
      if (hit(req, SSR_ADDR_EVT_MASK))    evt_mask_q    <= req.wdata;
      // Sleep ends when the wake fires
      if (hit(req, SSR_ADDR_SLEEP))       sleep_q       <= req.wdata[0];
      else if (core_q.wake)               sleep_q       <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rmux;
  always_comb
  begin
    rmux = SSR_RST_BYTE;
    case (req.addr)
      SSR_ADDR_BAUD_CTRL:   rmux = baud_ctrl_q;
      SSR_ADDR_CORE_IRQ:    rmux = core_irq_q;
      SSR_ADDR_PERIPH_PRIO: rmux = periph_prio_q;
      SSR_ADDR_PERIPH_EN:   rmux = periph_en_q;
      SSR_ADDR_PERIPH_FLAG: rmux = 8'(recv_flag_q) << SSR_PI_RECV;
      SSR_ADDR_RX_HOLD:     rmux = hold_q;
      SSR_ADDR_RX_STATUS:   rmux = {rx_ctrl_q[7:2], overrun_q, hold_ninth_q};
      SSR_ADDR_BAUD_LO:     rmux = baud_lo_q;
      SSR_ADDR_BAUD_HI:     rmux = baud_hi_q;
      SSR_ADDR_TX_STATUS:   rmux = tx_status_q;
      SSR_ADDR_PIN_DIR:     rmux = pin_dir_q;
      SSR_ADDR_EVT_STATUS:  rmux = {6'h00, evt_q};
      SSR_ADDR_EVT_MASK:    rmux = evt_mask_q;
      SSR_ADDR_SLEEP:       rmux = {7'h00, sleep_q};
      default:              rmux = SSR_RST_BYTE;
    endcase
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!nrst) rdata_q <= SSR_RST_BYTE;
    else       rdata_q <= req.rd ? rmux : SSR_RST_BYTE;
  end

  // ----------------------------------------------------------------
  // Outputs; slave receiver never drives its pins
  // ----------------------------------------------------------------
  logic pins_q;
  always_ff @(posedge clk)
  begin
    if (!nrst) pins_q <= 1'b0;
    else       pins_q <= 1'b0;
  end
  assign data_out = pins_q;
  assign data_oe  = pins_q;
  assign clk_out  = pins_q;
  assign clk_oe   = pins_q;
  assign rdata    = rdata_q;
  assign irq      = irq_q;
  assign core     = core_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_idle_never;
    @(posedge clk) disable iff (!nrst) rx_run |=> state_q != SSR_IDLE;
  endproperty
  a_idle_never: assert property (p_idle_never) else $error("receiver idled");

  property p_no_start;
    @(posedge clk) disable iff (!nrst) !rx_run |=> state_q == SSR_IDLE;
  endproperty
  a_no_start: assert property (p_no_start) else $error("started without enable");

  property p_move;
    @(posedge clk) disable iff (!nrst)
      (done && !recv_flag_q && port_en) |=> hold_q == $past(shift_q[7:0]);
  endproperty
  a_move: assert property (p_move) else $error("word not moved");

  property p_flag;
    @(posedge clk) disable iff (!nrst) load && port_en |=> recv_flag_q;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");

  property p_irq;
    @(posedge clk) disable iff (!nrst) irq_d |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_ovr_clr;
    @(posedge clk) disable iff (!nrst) !cont_en |=> !overrun_q;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept");

  property p_port_rst;
    @(posedge clk) disable iff (!nrst) !port_en |=> !recv_flag_q && !overrun_q;
  endproperty
  a_port_rst: assert property (p_port_rst) else $error("port not reset");

  property p_vector;
    @(posedge clk) disable iff (!nrst) core.vector |-> core.wake && $past(gl_en);
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");

  property p_wake;
    @(posedge clk) disable iff (!nrst) wake_d |=> core.wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_pins;
    @(posedge clk) disable iff (!nrst) !data_oe && !clk_oe;
  endproperty
  a_pins: assert property (p_pins) else $error("pin driven");

  // Vector only ever follows a cycle with every enable open
  property p_vec_gate;
    @(posedge clk) disable iff (!nrst) core.vector |-> $past(gl_en && pe_en && rc_en);
  endproperty
  a_vec_gate: assert property (p_vec_gate) else $error("vector not gated");

  // Top bit of a nine-bit word lands in the status field
  property p_ninth;
    @(posedge clk) disable iff (!nrst)
      (load && port_en && ninth_en) |=> hold_ninth_q == $past(shift_q[8]);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit lost");

  // Holding read returns the stored byte one cycle later
  property p_rd_hold;
    @(posedge clk) disable iff (!nrst)
      rd_hold |=> rdata == $past(hold_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("holding read wrong");

  // An overrunning word never replaces unread data
  property p_keep;
    @(posedge clk) disable iff (!nrst)
      (overrun_e && port_en) |=> hold_q == $past(hold_q);
  endproperty
  a_keep: assert property (p_keep) else $error("unread word replaced");

  c_word:    cover property (@(posedge clk) disable iff (!nrst) load);
  c_ninth:   cover property (@(posedge clk) disable iff (!nrst) load && ninth_en);
  c_overrun: cover property (@(posedge clk) disable iff (!nrst) overrun_e);
  c_wake:    cover property (@(posedge clk) disable iff (!nrst) core.wake);
  c_vector:  cover property (@(posedge clk) disable iff (!nrst) core.vector);

endmodule

// [ssr_pkg.sv]
// Purpose: Shared constants and types for the synchronous slave serial receiver
// Assumes: 8-bit register port, byte-wide registers at word indices below
// Notes:   Register map indices are local choices; bit positions follow the field layout
package ssr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] SSR_ADDR_BAUD_CTRL   = 4'h0;
  localparam logic [3:0] SSR_ADDR_CORE_IRQ    = 4'h1;
  localparam logic [3:0] SSR_ADDR_PERIPH_PRIO = 4'h2;
  localparam logic [3:0] SSR_ADDR_PERIPH_EN   = 4'h3;
  localparam logic [3:0] SSR_ADDR_PERIPH_FLAG = 4'h4;
  localparam logic [3:0] SSR_ADDR_RX_HOLD     = 4'h5;
  localparam logic [3:0] SSR_ADDR_RX_STATUS   = 4'h6;
  localparam logic [3:0] SSR_ADDR_BAUD_LO     = 4'h7;
  localparam logic [3:0] SSR_ADDR_BAUD_HI     = 4'h8;
  localparam logic [3:0] SSR_ADDR_TX_STATUS   = 4'h9;
  localparam logic [3:0] SSR_ADDR_PIN_DIR     = 4'ha;
  localparam logic [3:0] SSR_ADDR_EVT_STATUS  = 4'hb;
  localparam logic [3:0] SSR_ADDR_EVT_MASK    = 4'hc;
  localparam logic [3:0] SSR_ADDR_SLEEP       = 4'hd;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SSR_RS_PORT_EN  = 7;
  localparam int SSR_RS_NINTH_EN = 6;
  localparam int SSR_RS_SINGLE   = 5;
  localparam int SSR_RS_CONT     = 4;
  localparam int SSR_RS_OVERRUN  = 1;
  localparam int SSR_RS_NINTH    = 0;
  localparam int SSR_TS_MASTER   = 7;
  localparam int SSR_TS_SYNC     = 4;
  localparam int SSR_CI_GLOBAL   = 7;
  localparam int SSR_CI_PERIPH   = 6;
  localparam int SSR_PI_RECV     = 5;
  localparam int SSR_PD_DATA     = 0;
  localparam int SSR_PD_CLK      = 1;
  localparam int SSR_EV_RECV     = 0;
  localparam int SSR_EV_OVERRUN  = 1;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] SSR_RST_BYTE    = 8'h00;
  localparam logic [7:0] SSR_RST_PIN_DIR = 8'h03;
  localparam logic [3:0] SSR_BITS_8      = 4'h8;
  localparam logic [3:0] SSR_BITS_9      = 4'h9;
  localparam logic [3:0] SSR_CNT_ZERO    = 4'h0;
  localparam logic [3:0] SSR_CNT_ONE     = 4'h1;

  // Receive state, Gray coded along idle -> shift -> transfer
  typedef enum logic [1:0]
  {
    SSR_IDLE  = 2'b00,
    SSR_SHIFT = 2'b01,
    SSR_MOVE  = 2'b11
  } ssr_state_t;

  // Register port request
  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssr_req_t;

  // Core wake and vector outputs
  typedef struct packed
  {
    logic wake;
    logic vector;
  } ssr_core_t;

endpackage

// [ssr_master_model.sv]
// Purpose: Behavioural synchronous master that drives serial clock and data
// Assumes: Clock idles low between frames; data changes while clock is low
// Notes:   No pull-up on data, so after a frame it shows the inverse bit
`timescale 1ns/100ps
module ssr_master_model
#(
  parameter int HALF_NS = 200
)
(
  // Serial lines toward the slave
  output logic ser_clk,
  output logic ser_data
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial
  begin
    ser_clk  = 1'b0;
    ser_data = 1'b1;
  end

  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  // LSB first, one rising edge per bit; offset keeps edges off clk
  task automatic send(input logic [8:0] word, input logic nine);
    int n;
    int i;
    begin
      n = nine ? 9 : 8;
      #7;
      for (i = 0; i < n; i++)
      begin
        ser_data = word[i];
        #(HALF_NS);
        ser_clk = 1'b1;
        #(HALF_NS);
        ser_clk = 1'b0;
      end
      #(HALF_NS);
      ser_data = ~word[n-1]; // Released line must not hold last bit
    end
  endtask
endmodule

// [ssr_receiver_tb.sv]
// Purpose: Self-checking bench for the synchronous slave serial receiver
// Assumes: Register port strobes one cycle; read data the cycle after
// Notes:   Mask polarity is not assumed, only that the mask has effect
`timescale 1ns/100ps
module ssr_receiver_tb;
  import ssr_pkg::*;
  // Bench signals
  logic       clk;
  logic       nrst;
  ssr_req_t   bus_req;
  logic [7:0] rdata;
  logic       data_out;
  logic       data_oe;
  logic       clk_out;
  logic       clk_oe;
  ssr_core_t  core;
  logic       irq;
  logic       mst_clk;
  logic       mst_data;
  wire        data_wire;
  wire        clk_wire;
  int         error_cnt;
  int         total_checks;
  int         wake_cnt;
  int         vec_cnt;
  int         w0;
  int         v0;
  logic       oe_bad;
  logic       irq_a;
  logic [7:0] got;

  // Wire levels resolved from the receiver's enables; the master drives otherwise
  assign data_wire = data_oe ? data_out : mst_data;
  assign clk_wire  = clk_oe ? clk_out : mst_clk;

  ssr_receiver DUT (.clk(clk), .nrst(nrst), .req(bus_req), .rdata(rdata),
    .data_in(data_wire), .data_out(data_out), .data_oe(data_oe),
    .clk_in(clk_wire), .clk_out(clk_out), .clk_oe(clk_oe),
    .core(core), .irq(irq));

  ssr_master_model u_mst (.ser_clk(mst_clk), .ser_data(mst_data));

  // ----------------------------------------------------------------
  // Clock and monitors
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Wake may be short, so its cycles are counted here
  always @(posedge clk)
  begin
    if (core.wake === 1'b1)
      wake_cnt <= wake_cnt + 1;
    if (core.vector === 1'b1)
      vec_cnt <= vec_cnt + 1;
    if (nrst === 1'b1 && {data_oe, clk_oe, data_out, clk_out} !== 4'h0)
      oe_bad <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    begin
      @(posedge clk);
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      bus_req.wr    <= 1'b1;
      @(posedge clk);
      bus_req.wr <= 1'b0;
    end
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
      total_checks++;
      if (g !== e)
      begin
        error_cnt++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // Read data is looked at just after the edge that loads it
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
    begin
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.rd   <= 1'b1;
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      got = rdata;
      chk(nm, e, got);
    end
  endtask

  // Frame then settle; flag lands about four cycles after last rise
  task automatic xfer(input logic [8:0] w, input logic nine);
    begin
      u_mst.send(w, nine);
      repeat (3) @(posedge clk);
      #1;
    end
  endtask

  task automatic results;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Hang guard
  initial
  begin
    #(50 * 90000);
    error_cnt++;
    $display("[ERR] run_time expected end seen limit");
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    bus_req  = '0;
    nrst     = 1'b0;
    wake_cnt = 0;
    vec_cnt  = 0;
    oe_bad   = 1'b0;
    error_cnt    = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rdc(SSR_ADDR_RX_STATUS, 8'h00, "rx_status_reset");
    rdc(SSR_ADDR_PIN_DIR, SSR_RST_PIN_DIR, "pin_dir_reset");
    wr(4'he, 8'h5a);
    rdc(4'he, 8'h00, "unmapped");
    $display("test reset done");

    // Master select set, then continuous receive clear: nothing taken
    wr(SSR_ADDR_TX_STATUS, 8'h90);
    wr(SSR_ADDR_RX_STATUS, 8'hb0);
    xfer(9'h066, 1'b0);
    rdc(SSR_ADDR_PERIPH_FLAG, 8'h00, "flag_master");
    wr(SSR_ADDR_TX_STATUS, 8'h10);
    wr(SSR_ADDR_RX_STATUS, 8'h80);
    xfer(9'h066, 1'b0);
    rdc(SSR_ADDR_PERIPH_FLAG, 8'h00, "flag_nocont");
    rdc(SSR_ADDR_RX_HOLD, 8'h00, "hold_nocont");
    $display("test gating done");

    // Reception with single enable also set; interrupt gating and mask
    wr(SSR_ADDR_RX_STATUS, 8'hb0);
    wr(SSR_ADDR_PERIPH_EN, 8'h20);
    xfer(9'h0a5, 1'b0);
    rdc(SSR_ADDR_PERIPH_FLAG, 8'h20, "flag_set");
    wr(SSR_ADDR_EVT_MASK, 8'h00);
    repeat (2) @(posedge clk);
    irq_a = irq;
    wr(SSR_ADDR_EVT_MASK, 8'hff);
    repeat (2) @(posedge clk);
    chk("mask_effect", 8'h01, {7'h00, irq !== irq_a});
    rdc(SSR_ADDR_EVT_STATUS, 8'h01, "evt_word");
    repeat (2) @(posedge clk);
    chk("irq_no_global", 8'h00, {7'h00, irq});
    wr(SSR_ADDR_CORE_IRQ, 8'hc0);
    repeat (2) @(posedge clk);
    chk("irq_all_en", 8'h01, {7'h00, irq});
    rdc(SSR_ADDR_RX_HOLD, 8'ha5, "hold_a5");
    repeat (2) @(posedge clk);
    chk("irq_after_read", 8'h00, {7'h00, irq});
    xfer(9'h0ff, 1'b0);
    rdc(SSR_ADDR_RX_HOLD, 8'hff, "hold_ff");
    xfer(9'h000, 1'b0);
    rdc(SSR_ADDR_RX_HOLD, 8'h00, "hold_00");
    $display("test receive done");

    // Nine-bit words
    wr(SSR_ADDR_RX_STATUS, 8'hd0);
    xfer(9'h13c, 1'b1);
    rdc(SSR_ADDR_RX_STATUS, 8'hd1, "ninth_one");
    rdc(SSR_ADDR_RX_HOLD, 8'h3c, "hold_3c");
    xfer(9'h0c3, 1'b1);
    rdc(SSR_ADDR_RX_STATUS, 8'hd0, "ninth_zero");
    rdc(SSR_ADDR_RX_HOLD, 8'hc3, "hold_c3");
    $display("test nine done");

    // Overrun cleared by continuous receive, then by port enable
    wr(SSR_ADDR_RX_STATUS, 8'h90);
    rdc(SSR_ADDR_EVT_STATUS, 8'h01, "evt_pre");
    xfer(9'h011, 1'b0);
    xfer(9'h022, 1'b0);
    rdc(SSR_ADDR_RX_STATUS, 8'h92, "overrun_set");
    rdc(SSR_ADDR_EVT_STATUS, 8'h03, "evt_overrun");
    rdc(SSR_ADDR_RX_HOLD, 8'h11, "hold_kept");
    wr(SSR_ADDR_RX_STATUS, 8'h80);
    rdc(SSR_ADDR_RX_STATUS, 8'h80, "overrun_cont");
    wr(SSR_ADDR_RX_STATUS, 8'h90);
    xfer(9'h033, 1'b0);
    xfer(9'h044, 1'b0);
    wr(SSR_ADDR_RX_STATUS, 8'h10);
    rdc(SSR_ADDR_RX_STATUS, 8'h10, "overrun_port");
    rdc(SSR_ADDR_PERIPH_FLAG, 8'h00, "flag_port");
    $display("test overrun done");

    // Sleep: wake in line, then wake into the vector
    wr(SSR_ADDR_RX_STATUS, 8'h90);
    wr(SSR_ADDR_CORE_IRQ, 8'h00);
    wr(SSR_ADDR_SLEEP, 8'h01);
    w0 = wake_cnt;
    v0 = vec_cnt;
    xfer(9'h081, 1'b0);
    chk("wake_inline", 8'h01, {7'h00, wake_cnt != w0});
    chk("vec_inline", 8'h00, {7'h00, vec_cnt != v0});
    rdc(SSR_ADDR_RX_HOLD, 8'h81, "hold_sleep");
    wr(SSR_ADDR_CORE_IRQ, 8'hc0);
    wr(SSR_ADDR_SLEEP, 8'h01);
    w0 = wake_cnt;
    v0 = vec_cnt;
    xfer(9'h042, 1'b0);
    chk("wake_vec", 8'h01, {7'h00, wake_cnt != w0});
    chk("vec_taken", 8'h01, {7'h00, vec_cnt != v0});
    rdc(SSR_ADDR_RX_HOLD, 8'h42, "hold_vec");
    chk("pins_undriven", 8'h00, {7'h00, oe_bad});
    $display("test sleep done");
    results();
  end
endmodule
